// ==== hdl/ext_addr_pkg.sv ====
// constants for the extended-set operand address generator
package ext_addr_pkg;
  localparam int ADDR_W = 12;
  localparam int OPC_W = 16;
  localparam logic [7:0] INDEX_LIMIT = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam int ACC_BIT = 8;
  localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
  localparam logic [OPC_W-1:0] OPC_RST = 16'h0000;
  // extended opcode classes, first word; OPC_SECOND_WORD is the second-word prefix
  localparam logic [7:0] OPC_PTR_ARITH_ADD = 8'hE8;
  localparam logic [7:0] OPC_PTR_ARITH_SUB = 8'hE9;
  localparam logic [15:0] OPC_CALL_W = 16'h0014;
  localparam logic [8:0] OPC_MOVE_IDX_FILE = 9'h1D6;
  localparam logic [8:0] OPC_MOVE_IDX_IDX = 9'h1D7;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hEA;
  localparam logic [3:0] OPC_SECOND_WORD = 4'hF;
  typedef enum logic [2:0] {
    MODE_NONE = 3'b001,
    MODE_DIRECT = 3'b010,
    MODE_INDEXED = 3'b100
  } addr_mode_t;
endpackage : ext_addr_pkg

// ==== hdl/ext_addr_gen.sv ====
// operand address generation with indexed literal offset mode
`timescale 1ns/100ps
`default_nettype none
module ext_addr_gen (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // configuration
  input wire logic extended_set_enable,
  // instruction in
  input wire logic instr_valid,
  input wire logic [ext_addr_pkg::OPC_W-1:0] instr_word,
  input wire logic file_oriented,
  // core state
  input wire logic [3:0] bank_select_reg,
  input wire logic [ext_addr_pkg::ADDR_W-1:0] frame_pointer_pair,
  // results
  output logic addr_valid,
  output logic [ext_addr_pkg::ADDR_W-1:0] data_addr,
  output logic indexed_mode,
  output logic ext_instr,
  output logic ext_two_word
);
  import ext_addr_pkg::*;

  // added opcodes as mask and match pairs; pointer add and sub each cover two instructions
  localparam int N_PAT = 6;

  localparam logic [OPC_W-1:0] PAT_MASK [N_PAT] = '{
    16'hff00,
    16'hff00,
    16'hffff,
    16'hff80,
    16'hff80,
    16'hff00
  };

  localparam logic [OPC_W-1:0] PAT_VAL [N_PAT] = '{
    {OPC_PTR_ARITH_ADD, 8'h00},
    {OPC_PTR_ARITH_SUB, 8'h00},
    OPC_CALL_W,
    {OPC_MOVE_IDX_FILE, 7'h00},
    {OPC_MOVE_IDX_IDX, 7'h00},
    {OPC_PUSH_LIT, 8'h00}
  };

  // operand qualifies for indexed mode
  function automatic logic idx_ok(input logic [OPC_W-1:0] w);
    idx_ok = (w[ACC_BIT] == 1'b0) && (w[7:0] <= INDEX_LIMIT);
  endfunction : idx_ok

  // base core direct address: banked, or one of the two access bank halves
  function automatic logic [ADDR_W-1:0] base_addr(
    input logic [OPC_W-1:0] w,
    input logic [3:0] bank
  );
    logic [7:0] op;
    op = w[7:0];
    if (w[ACC_BIT]) begin
      base_addr = {bank, op};
    end else if (op < ACCESS_SPLIT) begin
      base_addr = {ACCESS_LO_BANK, op};
    end else begin
      base_addr = {ACCESS_HI_BANK, op};
    end
  endfunction : base_addr

  // offset is zero-extended; the carry out of the top bit is dropped on purpose
  function automatic logic [ADDR_W-1:0] idx_addr(
    input logic [OPC_W-1:0] w,
    input logic [ADDR_W-1:0] fp
  );
    logic [ADDR_W:0] sum;
    sum = {1'b0, fp} + {{(ADDR_W-7){1'b0}}, w[7:0]};
    idx_addr = sum[ADDR_W-1:0];
  endfunction : idx_addr

  logic [N_PAT-1:0] pat_hit;
  logic ext_hit;
  addr_mode_t mode;

  logic second_q;
  logic second_d;

  logic addr_valid_q;
  logic addr_valid_d;
  logic [ADDR_W-1:0] data_addr_q;
  logic [ADDR_W-1:0] data_addr_d;
  logic indexed_q;
  logic indexed_d;

  logic ext_q;
  logic ext_d;
  logic two_q;
  logic two_d;

  for (genvar g = 0; g < N_PAT; g++) begin : g_pat
    assign pat_hit[g] = (instr_word & PAT_MASK[g]) == PAT_VAL[g];
  end

  // with the set off the added opcodes fall back to the base decode
  assign ext_hit = extended_set_enable && (|pat_hit);

  // second words carry no operand, so the word after a first word is skipped
  always_comb begin
    second_d = second_q;
    if (instr_valid) begin
      if (second_q) begin
        second_d = 1'b0;
      end else begin
        second_d = ext_hit;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      second_q <= 1'b0;
    end else begin
      second_q <= second_d;
    end
  end

  always_comb begin
    mode = MODE_NONE;
    if (instr_valid && !second_q && !ext_hit && file_oriented) begin
      // literal and inherent ops never reach here, so they stay as in the base core
      if (extended_set_enable && idx_ok(instr_word)) begin
        mode = MODE_INDEXED;
      end else begin
        mode = MODE_DIRECT;
      end
    end
  end

  always_comb begin
    addr_valid_d = 1'b0;
    indexed_d = 1'b0;
    data_addr_d = data_addr_q;
    unique case (mode)
      MODE_NONE: begin
      end
      MODE_DIRECT: begin
        addr_valid_d = 1'b1;
        data_addr_d = base_addr(instr_word, bank_select_reg);
      end
      MODE_INDEXED: begin
        addr_valid_d = 1'b1;
        indexed_d = 1'b1;
        // bank and access bank deliberately ignored here
        data_addr_d = idx_addr(instr_word, frame_pointer_pair);
      end
    endcase
  end

  // program fetch is outside this block; pointer pairs one and two never pass here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr_valid_q <= 1'b0;
      data_addr_q <= ADDR_RST;
      indexed_q <= 1'b0;
    end else begin
      addr_valid_q <= addr_valid_d;
      data_addr_q <= data_addr_d;
      indexed_q <= indexed_d;
    end
  end

  always_comb begin
    ext_d = 1'b0;
    two_d = 1'b0;
    if (instr_valid && !second_q && ext_hit) begin
      ext_d = 1'b1;
      two_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ext_q <= 1'b0;
      two_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
      two_q <= two_d;
    end
  end

  assign addr_valid = addr_valid_q;
  assign data_addr = data_addr_q;
  assign indexed_mode = indexed_q;
  assign ext_instr = ext_q;
  assign ext_two_word = two_q;
endmodule : ext_addr_gen
`default_nettype wire

// ==== tb/ext_addr_gen_asserts.sv ====
// checker for the operand address generator
`timescale 1ns/100ps
`default_nettype none
module ext_addr_gen_asserts import ext_addr_pkg::*; (
  input wire logic clk_sys, rst, extended_set_enable, instr_valid, file_oriented,
  input wire logic addr_valid, indexed_mode, ext_instr, ext_two_word,
  input wire logic [OPC_W-1:0] instr_word,
  input wire logic [3:0] bank_select_reg,
  input wire logic [ADDR_W-1:0] frame_pointer_pair, data_addr
);
  wire logic e = extended_set_enable, v = instr_valid, a = instr_word[8];
  wire logic [7:0] op = instr_word[7:0];
  wire logic [3:0] f = {addr_valid, indexed_mode, ext_instr, ext_two_word};
  // coarse: skips all e-prefixed words, the bench judges those
  wire logic tk = v && file_oriented && !ext_instr && instr_word[15:12] != 4'he
    && instr_word != OPC_CALL_W;
  wire logic lo = tk && !a && op <= INDEX_LIMIT;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ext_decode_a: assert property (v && !ext_instr && e && instr_word[15:8] == OPC_PUSH_LIT
    |=> f == 4'h3) else $error("ext word");
  second_word_a: assert property (ext_instr && v |=> f == 4'h0) else $error("second");
  ext_off_a: assert property (!e && v && !file_oriented |=> f == 4'h0) else $error("off");
  idx_addr_a: assert property (lo && e |=> f == 4'hc
    && data_addr == $past(frame_pointer_pair) + $past(op)) else $error("indexed");
  bank_addr_a: assert property (tk && a |=> f == 4'h8
    && data_addr == {$past(bank_select_reg), $past(op)}) else $error("banked");
  access_hi_a: assert property (tk && !a && op > INDEX_LIMIT |=> f == 4'h8
    && data_addr == {ACCESS_HI_BANK, $past(op)}) else $error("upper");
  base_lo_a: assert property (lo && !e |=> f == 4'h8
    && data_addr == {ACCESS_LO_BANK, $past(op)}) else $error("lower");
  addr_hold_a: assert property (!addr_valid |-> $stable(data_addr)) else $error("moved");
  cover property (f == 4'hc);
  cover property (f == 4'h3 && v);
  cover property (lo && !e);
endmodule : ext_addr_gen_asserts
bind ext_addr_gen ext_addr_gen_asserts ext_addr_gen_asserts_i (.*);
`default_nettype wire

// ==== tb/ext_addr_gen_tb.sv ====
// random bench for the operand address generator
`timescale 1ns/100ps
`default_nettype none
module ext_addr_gen_tb;
  import ext_addr_pkg::*;
  logic clk_sys = 0, rst = 1, extended_set_enable = 0, instr_valid = 0, file_oriented = 0;
  logic addr_valid, indexed_mode, ext_instr, ext_two_word, xk = 0, sec, nxt = 0;
  logic [15:0] instr_word = 0, w, ex;
  logic [3:0] bank_select_reg = 0;
  logic [11:0] frame_pointer_pair = 0, data_addr;
  logic [31:0] r = 32'h0000_7c9d;
  int n_fail = 0, cmp_count = 0;
  ext_addr_gen ext_addr_gen_i (.*);
  initial forever #25 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13; x ^= x >> 17; return x ^ (x << 5);
  endfunction : xs
  // first word of an added instruction; codes 6 and 7 fold onto pointer add
  function automatic logic [15:0] ext_word(logic [2:0] sel, logic [7:0] lo);
    case (sel)
      3'h1: return {OPC_PTR_ARITH_SUB, lo};
      3'h2: return {OPC_PUSH_LIT, lo};
      3'h3: return OPC_CALL_W;
      3'h4: return {OPC_MOVE_IDX_FILE, lo[6:0]};
      3'h5: return {OPC_MOVE_IDX_IDX, lo[6:0]};
      default: return {OPC_PTR_ARITH_ADD, lo};
    endcase
  endfunction : ext_word
  task automatic cmp(logic [15:0] g, e);
    cmp_count++;
    if (g !== e) begin n_fail++; $display("MISMATCH %0t %h %h", $time, g, e); end
  endtask : cmp
  task automatic report_and_stop;
    if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // expected {valid, indexed, ext, two word, address}
  always @(posedge clk_sys) begin
    ex[15:12] = 0;
    if (rst) begin ex = 0; sec = 0; end
    else if (instr_valid && sec) sec = 0;
    else if (instr_valid && extended_set_enable && xk) begin ex[15:12] = 4'h3; sec = 1; end
    else if (instr_valid && file_oriented) begin
      ex[15] = 1;
      ex[14] = extended_set_enable && !instr_word[8] && instr_word[7:0] <= INDEX_LIMIT;
      ex[11:0] = {instr_word[8] ? bank_select_reg : {4{instr_word[7:0] > 8'h5f}}, instr_word[7:0]};
      if (ex[14]) ex[11:0] = frame_pointer_pair + instr_word[7:0];
    end
  end
  always @(negedge clk_sys) if (!rst) cmp({addr_valid, indexed_mode, ext_instr, ext_two_word,
    data_addr}, ex);
  initial begin
    for (int ph = 0; ph < 3; ph++) begin
      rst <= 1;
      instr_valid <= 0;
      extended_set_enable <= ph != 0;
      repeat (4) @(posedge clk_sys);
      rst <= 0;
      repeat (300) begin
        @(posedge clk_sys);
        r = xs(r);
        w = {2'b01, r[13:0]};
        if (r[18]) w[7:0] = r[17] ? 8'h5f + r[16] : {8{r[16]}};
        if (r[21:19] == 0) w = ext_word(r[24:22], w[7:0]);
        instr_valid <= r[0] | r[1] | nxt;
        nxt = r[21:19] == 0;
        xk <= nxt;
        instr_word <= w;
        file_oriented <= r[2];
        bank_select_reg <= r[7:4];
        frame_pointer_pair <= r[27] ? 12'hfff : r[31:20];
      end
    end
    repeat (2) @(posedge clk_sys);
    report_and_stop;
  end
  initial begin
    repeat (1200) @(posedge clk_sys);
    n_fail++;
    report_and_stop;
  end
endmodule : ext_addr_gen_tb
`default_nettype wire
